/* File: rtl/dvl_pkg.sv */
// shared constants for the diagnostic-verification logic, both ends
package dvl_pkg;
  // comparator bit positions inside the synchroniser vector
  localparam int C_BRO = 0;  // bridge supply open
  localparam int C_PHA = 1;  // phase a above threshold
  localparam int C_PHB = 2;  // phase b above threshold
  localparam int C_SAD = 3;  // sense amp input open
  localparam int C_LSO = 4;  // low-side source open
  localparam int C_RUV = 5;  // regulator undervoltage
  localparam int C_ROV = 6;  // regulator overvoltage
  localparam int C_TW = 7;   // temperature warning
  localparam int C_OT = 8;   // overtemperature
  localparam int C_SUV = 9;  // supply undervoltage
  localparam int C_SOV = 10; // supply overvoltage
  localparam int C_GUV = 11; // gate uv, four bits: high a, high b, low a, low b
  localparam int NCMP = 15;

  // gate order in every 4-bit gate vector
  localparam int G_HA = 0;
  localparam int G_HB = 1;
  localparam int G_LA = 2;
  localparam int G_LB = 3;

  // sticky flag positions
  localparam int F_BRO = 0;  // bridge_supply_open_flag
  localparam int F_SAD = 1;  // sense_amp_open_flag
  localparam int F_LSD = 2;  // low_source_open_flags, two bits
  localparam int F_PAC = 4;  // phase_connected_flag
  localparam int F_HAD = 5;  // high a drain fault
  localparam int F_HBD = 6;  // high b drain fault
  localparam int F_LAD = 7;  // low_a_drain_fault
  localparam int F_LBD = 8;  // low_b_drain_fault
  localparam int F_RUV = 9;  // reg_undervolt_flag
  localparam int F_ROV = 10; // reg_overvolt_flag
  localparam int F_TW = 11;  // temp_warning_flag
  localparam int F_OT = 12;  // over_temp_flag
  localparam int F_SUV = 13; // supply_undervolt_flag
  localparam int F_SOV = 14; // supply_overvolt_flag
  localparam int F_GUV = 15; // gate uv flags, four bits in gate order
  localparam int NFLAG = 19;
  localparam logic [NFLAG-1:0] FLAGS_RST = 19'h00000;

  // reset values of host configuration
  localparam logic [1:0] BRO_SEL_RST = 2'h0;
  localparam logic [5:0] PT_CODE_RST = 6'h20;

  // host test timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_NS = 2000;
  localparam int TEST_NS = 20000;
  localparam int EVAL_NS = 200;
  localparam logic [15:0] SETTLE_CYC = 16'(SETTLE_NS / CLK_PERIOD_NS);
  localparam logic [15:0] TEST_CYC = 16'(TEST_NS / CLK_PERIOD_NS);
  localparam logic [15:0] EVAL_CYC = 16'(EVAL_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_ON = 3'b001,
    H_TEST = 3'b010,
    H_EVAL = 3'b011,
    H_NEXT = 3'b100
  } dvl_hstate_t;
endpackage

/* File: rtl/dvl_if.sv */
// loose command and flag bits between the host and the gate-driver verify logic
interface dvl_if (
  input wire logic clk,     // common clock
  input wire logic sys_rst  // synchronous reset, active high
);
  import dvl_pkg::*;
  logic [3:0] gate_cmd;
  logic stop_on_fault;
  logic [1:0] bridge_open_threshold_sel;
  logic [5:0] phase_threshold_code;
  logic ds_mask;
  logic pull_down_test_cmd;
  logic pull_up_test_cmd;
  logic reg_undervolt_test_cmd;
  logic reg_overvolt_test_cmd;
  logic temp_warning_test_cmd;
  logic overtemp_test_cmd;
  logic supply_undervolt_test_cmd;
  logic supply_overvolt_test_cmd;
  logic gate_undervolt_test_cmd;
  logic [NFLAG-1:0] flag_read;
  logic [NFLAG-1:0] flags;
  logic phase_a_state;
  logic phase_b_state;
  logic fault_active;

  modport device (
    input clk, sys_rst, gate_cmd, stop_on_fault, bridge_open_threshold_sel,
    input phase_threshold_code, ds_mask, pull_down_test_cmd, pull_up_test_cmd,
    input reg_undervolt_test_cmd, reg_overvolt_test_cmd, temp_warning_test_cmd,
    input overtemp_test_cmd, supply_undervolt_test_cmd, supply_overvolt_test_cmd,
    input gate_undervolt_test_cmd, flag_read,
    output flags, phase_a_state, phase_b_state, fault_active
  );
  modport host (
    input clk, sys_rst, flags, phase_a_state, phase_b_state, fault_active,
    output gate_cmd, stop_on_fault, bridge_open_threshold_sel,
    output phase_threshold_code, ds_mask, pull_down_test_cmd, pull_up_test_cmd,
    output reg_undervolt_test_cmd, reg_overvolt_test_cmd, temp_warning_test_cmd,
    output overtemp_test_cmd, supply_undervolt_test_cmd, supply_overvolt_test_cmd,
    output gate_undervolt_test_cmd, flag_read
  );
endinterface

/* File: rtl/dvl_device.sv */
// device end: connection monitors, forced-comparator tests and sticky flags
//
// How it works
// [RULE_01] bridge-open threshold is (sel+1) times 2 V
// [RULE_02] bridge open sets flag and high drain faults
// [RULE_03] stop-on-fault blocks gates while open persists
// [RULE_04] bridge flags stay until software clears
// [RULE_05] phase states track comparators; code sets n/64
// [RULE_06] sense amp open sets its flag
// [RULE_07] source open sets both open and low-drain flags
// [RULE_08] tests run only while their command bit
// [RULE_09] pull-down cleared with phase high marks connected
// [RULE_10] pull-up cleared with phase low marks connected
// [RULE_11] connection judged only when test bit falls
// [RULE_12] host tests both sides of both phases
// [RULE_13] host masks drain fault detection during phase tests
// [RULE_14] regulator undervolt test latches its flag
// [RULE_15] regulator overvolt test latches its flag
// [RULE_16] temperature warning test latches its flag
// [RULE_17] overtemperature test latches its flag
// [RULE_18] supply undervolt test latches; fault state ends
// [RULE_19] supply overvolt test latches its flag
// [RULE_20] gate uv test: opposite gate trips its comparator
// [RULE_21] command or gates off ends uv fault states
// [RULE_22] flags clear only on reset or read
// [RULE_23] comparators pass two flops before any use

////////////////////////////////////////////////////////////////////////////////
// two-flop level synchroniser, one bit per lane
module dvl_sync #(
  parameter int W = 1  // lane count
) (
  input wire logic clk,        // clock
  input wire logic sys_rst,    // synchronous reset
  input wire logic [W-1:0] d,  // asynchronous levels
  output logic [W-1:0] q       // synchronised levels
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module dvl_device
  import dvl_pkg::*;
(
  dvl_if.device bus,                    // host side bits
  input wire logic [NCMP-1:0] cmp_raw,  // analog comparator outputs
  output logic [3:0] gate_drive,        // gate outputs after fault gating
  output logic [1:0] bro_sel,           // bridge-open threshold select to analog
  output logic [5:0] pt_code,           // phase threshold dac code
  output logic pull_down_en,            // pull-down test current on
  output logic pull_up_en,              // pull-up test current on
  output logic [5:0] cmp_force,         // forced trip: ruv rov tw ot suv sov
  output logic [3:0] guv_force,         // forced gate uv trip, gate order
  output logic ds_mask_out              // drain fault detection masked
);
  logic [NCMP-1:0] cmp_s;
  logic [NFLAG-1:0] flags_r;
  logic [NFLAG-1:0] set_vec;
  logic pd_prev_r;
  logic pu_prev_r;
  logic tested_phase;
  logic open_state;
  logic [5:0] force_nxt;
  logic [3:0] guv_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // [RULE_23] comparator synchroniser
  dvl_sync #(.W(NCMP)) u_sync (
    .clk(bus.clk),
    .sys_rst(bus.sys_rst),
    .d(cmp_raw),
    .q(cmp_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // [RULE_08] forces exist only while a command bit stands
  always_comb begin
    force_nxt = {bus.supply_overvolt_test_cmd, bus.supply_undervolt_test_cmd,
                 bus.overtemp_test_cmd, bus.temp_warning_test_cmd,
                 bus.reg_overvolt_test_cmd, bus.reg_undervolt_test_cmd};
    // [RULE_20] high-side uv forced by its low gate and vice versa
    guv_nxt[G_HA] = bus.gate_undervolt_test_cmd & bus.gate_cmd[G_LA];
    guv_nxt[G_HB] = bus.gate_undervolt_test_cmd & bus.gate_cmd[G_LB];
    guv_nxt[G_LA] = bus.gate_undervolt_test_cmd & bus.gate_cmd[G_HA];
    guv_nxt[G_LB] = bus.gate_undervolt_test_cmd & bus.gate_cmd[G_HB];
  end

  // [RULE_21] forces drop with the command; gate uv forces also drop when their opposite gate is off
  always_ff @(posedge bus.clk) begin
    if (bus.sys_rst) begin
      cmp_force <= 6'h00;
      guv_force <= 4'h0;
    end else begin
      cmp_force <= force_nxt;
      guv_force <= guv_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog settings; threshold maths is in the comparator, we only pass codes
  always_ff @(posedge bus.clk) begin
    if (bus.sys_rst) begin
      bro_sel <= BRO_SEL_RST;
      pt_code <= PT_CODE_RST;
      pull_down_en <= 1'b0;
      pull_up_en <= 1'b0;
      ds_mask_out <= 1'b0;
    end else begin
      // [RULE_01] threshold select to comparator
      bro_sel <= bus.bridge_open_threshold_sel;
      // [RULE_05] phase dac code
      pt_code <= bus.phase_threshold_code;
      // [RULE_09] pull-down current follows its bit
      pull_down_en <= bus.pull_down_test_cmd;
      // [RULE_10] pull-up current follows its bit
      pull_up_en <= bus.pull_up_test_cmd;
      // [RULE_13] mask passed on to drain detectors
      ds_mask_out <= bus.ds_mask;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // [RULE_03] gates held off during an open fault with stop-on-fault;
  // the analog hysteresis decides when the open state ends
  assign open_state = cmp_s[C_BRO] | cmp_s[C_LSO];

  always_ff @(posedge bus.clk) begin
    if (bus.sys_rst) begin
      gate_drive <= 4'h0;
    end else if (bus.stop_on_fault && open_state) begin
      gate_drive <= 4'h0;
    end else begin
      gate_drive <= bus.gate_cmd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // test bit history for falling-edge evaluation
  always_ff @(posedge bus.clk) begin
    if (bus.sys_rst) begin
      pd_prev_r <= 1'b0;
      pu_prev_r <= 1'b0;
    end else begin
      pd_prev_r <= bus.pull_down_test_cmd;
      pu_prev_r <= bus.pull_up_test_cmd;
    end
  end

  // phase under test is b when either b gate is commanded, else a
  assign tested_phase = (bus.gate_cmd[G_HB] | bus.gate_cmd[G_LB]) ? cmp_s[C_PHB] : cmp_s[C_PHA];

  //////////////////////////////////////////////////////////////////////////////
  // hardware set terms for the sticky flags
  always_comb begin
    set_vec = FLAGS_RST;
    // [RULE_02] bridge open flag plus high drain faults
    set_vec[F_BRO] = cmp_s[C_BRO];
    set_vec[F_HAD] = cmp_s[C_BRO];
    set_vec[F_HBD] = cmp_s[C_BRO];
    // [RULE_06] sense amp open
    set_vec[F_SAD] = cmp_s[C_SAD];
    // [RULE_07] both source-open bits and low drain faults
    set_vec[F_LSD] = cmp_s[C_LSO];
    set_vec[F_LSD+1] = cmp_s[C_LSO];
    set_vec[F_LAD] = cmp_s[C_LSO];
    set_vec[F_LBD] = cmp_s[C_LSO];
    // [RULE_11] judged only on the falling test bit
    // [RULE_09] pull-down test passes on phase high
    // [RULE_10] pull-up test passes on phase low
    set_vec[F_PAC] = (pd_prev_r & ~bus.pull_down_test_cmd & tested_phase) |
                     (pu_prev_r & ~bus.pull_up_test_cmd & ~tested_phase);
    // [RULE_14] regulator undervolt
    set_vec[F_RUV] = cmp_s[C_RUV];
    // [RULE_15] regulator overvolt
    set_vec[F_ROV] = cmp_s[C_ROV];
    // [RULE_16] temperature warning
    set_vec[F_TW] = cmp_s[C_TW];
    // [RULE_17] overtemperature
    set_vec[F_OT] = cmp_s[C_OT];
    // [RULE_18] supply undervolt
    set_vec[F_SUV] = cmp_s[C_SUV];
    // [RULE_19] supply overvolt
    set_vec[F_SOV] = cmp_s[C_SOV];
    // [RULE_20] gate uv flags, gate order
    set_vec[F_GUV +: 4] = cmp_s[C_GUV +: 4];
  end

  //////////////////////////////////////////////////////////////////////////////
  // [RULE_04] flags are sticky
  // [RULE_22] only reset or a read clears, and a set in that cycle wins
  always_ff @(posedge bus.clk) begin
    if (bus.sys_rst) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~bus.flag_read) | set_vec;
    end
  end

  assign bus.flags = flags_r;

  //////////////////////////////////////////////////////////////////////////////
  // [RULE_05] phase states copied every cycle
  always_ff @(posedge bus.clk) begin
    if (bus.sys_rst) begin
      bus.phase_a_state <= 1'b0;
      bus.phase_b_state <= 1'b0;
    end else begin
      bus.phase_a_state <= cmp_s[C_PHA];
      bus.phase_b_state <= cmp_s[C_PHB];
    end
  end

  // [RULE_18] general fault follows live states, so it ends with the command
  always_ff @(posedge bus.clk) begin
    if (bus.sys_rst) begin
      bus.fault_active <= 1'b0;
    end else begin
      bus.fault_active <= open_state | (|cmp_s[C_RUV +: 6]) | (|cmp_s[C_GUV +: 4]);
    end
  end
endmodule

/* File: rtl/dvl_host.sv */
// host end: drives command bits, runs sequenced tests, reads and clears flags
module dvl_host
  import dvl_pkg::*;
(
  dvl_if.host bus,                   // device side bits
  input wire logic [3:0] gate_req,   // gate commands when idle
  input wire logic sof_req,          // stop-on-fault setting
  input wire logic [1:0] bro_req,    // bridge-open threshold select
  input wire logic [5:0] pt_req,     // phase threshold code
  input wire logic [5:0] force_req,  // forced tests: ruv rov tw ot suv sov
  input wire logic phase_start,      // pulse: run four phase tests
  input wire logic guv_start,        // pulse: run four gate uv tests
  input wire logic read_req,         // pulse: read and clear all flags
  output logic [NFLAG-1:0] flags_seen, // flags captured at last read
  output logic [3:0] pass_mask,      // per step result of last sequence
  output logic busy                  // sequence running
);
  dvl_hstate_t state_r;
  logic [15:0] cnt_r;
  logic [1:0] step_r;
  logic mode_uv_r;
  logic [NFLAG-1:0] capture_bit;

  assign busy = (state_r != H_IDLE);

  // flag that the current step should have set
  always_comb begin
    capture_bit = FLAGS_RST;
    if (mode_uv_r) begin
      capture_bit[F_GUV + int'(step_r ^ 2'h2)] = 1'b1;
    end else begin
      capture_bit[F_PAC] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // [RULE_12] step through high a, high b, low a, low b
  // [RULE_20] same order for the gate uv sweep
  always_ff @(posedge bus.clk) begin
    if (bus.sys_rst) begin
      state_r <= H_IDLE;
      cnt_r <= 16'h0000;
      step_r <= 2'h0;
      mode_uv_r <= 1'b0;
    end else begin
      unique case (state_r)
        H_IDLE: begin
          cnt_r <= 16'h0000;
          step_r <= 2'h0;
          if (phase_start || guv_start) begin
            mode_uv_r <= guv_start & ~phase_start;
            state_r <= H_ON;
          end
        end
        H_ON: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == SETTLE_CYC - 16'h0001) begin
            cnt_r <= 16'h0000;
            state_r <= mode_uv_r ? H_EVAL : H_TEST;
          end
        end
        // [RULE_11] test length is set by when the bit is dropped
        H_TEST: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == TEST_CYC - 16'h0001) begin
            cnt_r <= 16'h0000;
            state_r <= H_EVAL;
          end
        end
        H_EVAL: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == EVAL_CYC - 16'h0001) begin
            cnt_r <= 16'h0000;
            state_r <= H_NEXT;
          end
        end
        H_NEXT: begin
          step_r <= step_r + 2'h1;
          state_r <= (step_r == 2'h3) ? H_IDLE : H_ON;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // results and flag reads; a read clears exactly what was seen
  always_ff @(posedge bus.clk) begin
    if (bus.sys_rst) begin
      pass_mask <= 4'h0;
      flags_seen <= FLAGS_RST;
      bus.flag_read <= FLAGS_RST;
    end else if (state_r == H_NEXT) begin
      pass_mask[step_r] <= |(bus.flags & capture_bit);
      bus.flag_read <= capture_bit;
    end else if (read_req && state_r == H_IDLE) begin
      flags_seen <= bus.flags;
      bus.flag_read <= bus.flags;
    end else begin
      if (phase_start || guv_start) begin
        pass_mask <= 4'h0;
      end
      bus.flag_read <= FLAGS_RST;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command bits; sequences own the gates and test bits while busy
  always_ff @(posedge bus.clk) begin
    if (bus.sys_rst) begin
      bus.gate_cmd <= 4'h0;
      bus.stop_on_fault <= 1'b0;
      bus.bridge_open_threshold_sel <= BRO_SEL_RST;
      bus.phase_threshold_code <= PT_CODE_RST;
      bus.ds_mask <= 1'b0;
      bus.pull_down_test_cmd <= 1'b0;
      bus.pull_up_test_cmd <= 1'b0;
      bus.gate_undervolt_test_cmd <= 1'b0;
      {bus.supply_overvolt_test_cmd, bus.supply_undervolt_test_cmd,
       bus.overtemp_test_cmd, bus.temp_warning_test_cmd,
       bus.reg_overvolt_test_cmd, bus.reg_undervolt_test_cmd} <= 6'h00;
    end else begin
      bus.stop_on_fault <= sof_req;
      bus.bridge_open_threshold_sel <= bro_req;
      bus.phase_threshold_code <= pt_req;
      {bus.supply_overvolt_test_cmd, bus.supply_undervolt_test_cmd,
       bus.overtemp_test_cmd, bus.temp_warning_test_cmd,
       bus.reg_overvolt_test_cmd, bus.reg_undervolt_test_cmd} <= busy ? 6'h00 : force_req;
      if (state_r == H_ON || state_r == H_TEST || (state_r == H_EVAL && !mode_uv_r)) begin
        bus.gate_cmd <= 4'(1 << step_r);
      end else if (busy) begin
        bus.gate_cmd <= 4'h0;
      end else begin
        bus.gate_cmd <= gate_req;
      end
      // [RULE_13] drain detection masked for phase tests
      bus.ds_mask <= busy & ~mode_uv_r;
      bus.pull_down_test_cmd <= (state_r == H_TEST) && !step_r[1];
      bus.pull_up_test_cmd <= (state_r == H_TEST) && step_r[1];
      bus.gate_undervolt_test_cmd <= busy & mode_uv_r;
    end
  end
endmodule

/* File: tb/dvl_monitor.sv */
// concurrent checks on the host-device interface bits
module dvl_monitor
  import dvl_pkg::*;
(
  input wire logic clk,                        // common clock
  input wire logic sys_rst,                    // synchronous reset
  input wire logic [3:0] gate_cmd,             // gate commands
  input wire logic ds_mask,                    // drain fault mask
  input wire logic pull_down_test_cmd,         // pull-down test bit
  input wire logic pull_up_test_cmd,           // pull-up test bit
  input wire logic reg_undervolt_test_cmd,     // forced regulator uv
  input wire logic supply_undervolt_test_cmd,  // forced supply uv
  input wire logic gate_undervolt_test_cmd,    // gate uv test bit
  input wire logic [NFLAG-1:0] flag_read,      // read-clear pulses
  input wire logic [NFLAG-1:0] flags,          // sticky flags
  input wire logic fault_active                // live general fault
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // helper terms; counter measures how long a phase test bit is held
  logic test_any;
  logic uv_la;
  logic [15:0] run_cnt;
  assign test_any = pull_down_test_cmd | pull_up_test_cmd;
  assign uv_la = gate_undervolt_test_cmd & gate_cmd[G_LA];
  always_ff @(posedge clk) begin
    if (sys_rst || !test_any) begin
      run_cnt <= 16'h0000;
    end else begin
      run_cnt <= run_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // a flag may only drop after its read pulse
  chk_flag_sticky: assert property (
    !(|($past(flags) & ~flags & ~$past(flag_read))))
    else $error("flag dropped without read");
  chk_bro_pairs: assert property (
    $rose(flags[F_BRO]) |-> flags[F_HAD] && flags[F_HBD])
    else $error("bridge open without high drain flags");
  chk_lso_pairs: assert property (
    $rose(flags[F_LSD]) |-> flags[F_LSD+1] && flags[F_LAD] && flags[F_LBD])
    else $error("source open without its partner flags");
  chk_pac_on_fall: assert property (
    $rose(flags[F_PAC]) |-> !test_any && ($past(test_any) || $past(test_any, 2)
    || $past(test_any, 3)))
    else $error("phase connected set without test bit fall");
  chk_phase_setup: assert property (
    $rose(test_any) |-> ds_mask && $onehot(gate_cmd))
    else $error("phase test started without mask or single gate");
  chk_test_length: assert property (
    $fell(test_any) |-> run_cnt == TEST_CYC)
    else $error("phase test bit held wrong length");
  chk_uv_trip: assert property (
    $rose(uv_la) |-> ##[1:10] flags[F_GUV+G_HA])
    else $error("gate uv high a flag not latched");
  chk_ruv_latch: assert property (
    $rose(reg_undervolt_test_cmd) |-> ##[1:8] flags[F_RUV])
    else $error("regulator uv flag not latched");
  chk_fault_live: assert property (
    $fell(supply_undervolt_test_cmd) |-> ##[1:8] !fault_active)
    else $error("general fault stays after supply uv test");
endmodule

/* File: tb/tb_diagnostic_verification_logic.sv */
// self-checking bench: host and device joined, analog modelled here
module tb_diagnostic_verification_logic
  import dvl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [NCMP-1:0] cmp_raw = '0;
  logic [3:0] gate_drive, gate_req = 4'h0, guv_force;
  logic [1:0] bro_sel, bro_req = 2'h0;
  logic [5:0] pt_code, pt_req = 6'h20, cmp_force, force_req = 6'h00;
  logic pull_down_en, pull_up_en, ds_mask_out, busy;
  logic sof_req = 1'b0, phase_start = 1'b0, guv_start = 1'b0, read_req = 1'b0;
  logic ext_bro = 1'b0, ext_sad = 1'b0, ext_lso = 1'b0, disc_a = 1'b0;
  logic [NFLAG-1:0] flags_seen;
  logic [3:0] pass_mask;
  logic [31:0] v;
  int n_mismatch = 0;
  int n_tests = 0;

  always #10 clk = ~clk;

  dvl_if bus_if (.clk(clk), .sys_rst(sys_rst));
  dvl_device i_dvl_device (.bus(bus_if), .cmp_raw(cmp_raw), .gate_drive(gate_drive),
    .bro_sel(bro_sel), .pt_code(pt_code), .pull_down_en(pull_down_en),
    .pull_up_en(pull_up_en), .cmp_force(cmp_force), .guv_force(guv_force),
    .ds_mask_out(ds_mask_out));
  dvl_host i_dvl_host (.bus(bus_if), .gate_req(gate_req), .sof_req(sof_req),
    .bro_req(bro_req), .pt_req(pt_req), .force_req(force_req), .phase_start(phase_start),
    .guv_start(guv_start), .read_req(read_req), .flags_seen(flags_seen),
    .pass_mask(pass_mask), .busy(busy));
  dvl_monitor i_dvl_monitor (.clk(clk), .sys_rst(sys_rst), .gate_cmd(bus_if.gate_cmd),
    .ds_mask(bus_if.ds_mask), .pull_down_test_cmd(bus_if.pull_down_test_cmd),
    .pull_up_test_cmd(bus_if.pull_up_test_cmd),
    .reg_undervolt_test_cmd(bus_if.reg_undervolt_test_cmd),
    .supply_undervolt_test_cmd(bus_if.supply_undervolt_test_cmd),
    .gate_undervolt_test_cmd(bus_if.gate_undervolt_test_cmd),
    .flag_read(bus_if.flag_read), .flags(bus_if.flags), .fault_active(bus_if.fault_active));

  ////////////////////////////////////////////////////////////////////////////////
  // analog side: a live gate pins its phase node, a broken phase follows test currents
  always @(posedge clk) begin
    cmp_raw[C_BRO] <= ext_bro;
    cmp_raw[C_SAD] <= ext_sad;
    cmp_raw[C_LSO] <= ext_lso;
    cmp_raw[C_PHA] <= disc_a ? (pull_up_en & ~pull_down_en)
                             : (gate_drive[G_HA] | (~gate_drive[G_LA] & pull_up_en));
    cmp_raw[C_PHB] <= gate_drive[G_HB] | (~gate_drive[G_LB] & pull_up_en);
    cmp_raw[C_SOV:C_RUV] <= cmp_force;
    cmp_raw[C_GUV+:4] <= guv_force;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  function automatic logic [31:0] fb(input int p);
    return 32'h1 << p;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // read pulse copies and clears the flags; flags_seen settles one edge later
  task automatic rd(output logic [31:0] val);
    @(posedge clk) read_req <= 1'b1;
    @(posedge clk) read_req <= 1'b0;
    wait_cyc(2);
    val = 32'(flags_seen);
  endtask
  // bounded wait for a host sequence; limit is well above the longest sequence
  task automatic wait_idle();
    int i;
    i = 0;
    wait_cyc(2);
    while (busy !== 1'b0 && i < 6000) begin
      wait_cyc(1);
      i++;
    end
    check(32'(i < 6000), 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    check(32'({busy, pass_mask, flags_seen}), 32'h0);
    check(32'({bro_sel, pt_code}), 32'({BRO_SEL_RST, PT_CODE_RST}));
  endtask
  task automatic t_config();
    logic [3:0] g [3] = '{4'h1, 4'h4, 4'h2};
    logic [1:0] e [3] = '{2'b10, 2'b00, 2'b01};
    for (int n = 0; n < 4; n++) begin
      @(posedge clk) bro_req <= 2'(n);
      pt_req <= 6'(n * 21);
      wait_cyc(4);
      check(32'({bro_sel, pt_code}), 32'({2'(n), 6'(n * 21)}));
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) gate_req <= g[k];
      wait_cyc(10);
      check(32'({bus_if.phase_a_state, bus_if.phase_b_state}), 32'(e[k]));
    end
    @(posedge clk) gate_req <= 4'h0;
  endtask
  task automatic t_bridge_open();
    @(posedge clk) sof_req <= 1'b1;
    gate_req <= 4'h1;
    ext_bro <= 1'b1;
    wait_cyc(10);
    check(32'(gate_drive), 32'h0);
    @(posedge clk) ext_bro <= 1'b0;
    wait_cyc(10);
    check(32'(gate_drive), 32'h1);
    rd(v);
    check(v, fb(F_BRO) | fb(F_HAD) | fb(F_HBD));
    rd(v);
    check(v, 32'h0);
    @(posedge clk) sof_req <= 1'b0;
    gate_req <= 4'h0;
  endtask
  task automatic t_lso_sad();
    @(posedge clk) ext_lso <= 1'b1;
    ext_sad <= 1'b1;
    wait_cyc(10);
    @(posedge clk) ext_lso <= 1'b0;
    ext_sad <= 1'b0;
    wait_cyc(6);
    rd(v);
    check(v, fb(F_SAD) | (32'h3 << F_LSD) | fb(F_LAD) | fb(F_LBD));
  endtask
  task automatic t_forced();
    for (int k = 0; k < 6; k++) begin
      @(posedge clk) force_req <= 6'(1 << k);
      wait_cyc(10);
      check(32'(bus_if.fault_active), 32'h1);
      @(posedge clk) force_req <= 6'h00;
      wait_cyc(10);
      check(32'(bus_if.fault_active), 32'h0);
      rd(v);
      check(v, fb(F_RUV + k));
    end
  endtask
  task automatic t_phase(input logic broken, input logic [3:0] exp);
    @(posedge clk) disc_a <= broken;
    phase_start <= 1'b1;
    @(posedge clk) phase_start <= 1'b0;
    // first step is in its test window here: mask on, pull-down current on
    wait_cyc(int'(SETTLE_CYC) + 4);
    check(32'({ds_mask_out, pull_down_en, pull_up_en}), 32'h6);
    wait_idle();
    check(32'(pass_mask), 32'(exp));
    @(posedge clk) disc_a <= 1'b0;
  endtask
  task automatic t_guv();
    @(posedge clk) guv_start <= 1'b1;
    @(posedge clk) guv_start <= 1'b0;
    wait_idle();
    check(32'(pass_mask), 32'hf);
    check(32'(guv_force), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and run control
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs about 9600 cycles
  initial begin
    repeat (25000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    wait_cyc(2);
    t_reset();
    t_config();
    t_bridge_open();
    t_lso_sad();
    t_forced();
    t_phase(1'b0, 4'hf);
    t_phase(1'b1, 4'ha);
    t_guv();
    tally_and_finish();
  end
endmodule
